// [src/rrm_refresh_host.sv]
// Purpose: Refresh scheduler driving refresh and mode register writes
// Assumes: Device follows the commands; software programs over APB
// Notes:   Mode changes of refresh rate wait for whole groups of fast refreshes
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module rrm_refresh_host #(
   parameter int TW = 8
) (
   input  wire logic                        clock_i,
   input  wire logic                        resetn_i,
   input  wire logic                        psel_i,
   input  wire logic                        penable_i,
   input  wire logic                        pwrite_i,
   input  wire logic [rrm_pkg::ADDR_W-1:0]  paddr_i,
   input  wire logic [rrm_pkg::DATA_W-1:0]  pwdata_i,
   output logic      [rrm_pkg::DATA_W-1:0]  prdata_o,
   output logic                             pready_o,
   output logic                             pslverr_o,
   output rrm_pkg::rrm_cmd_t                cmd_o
);
   import rrm_pkg::*;

   function automatic rrm_kind_t high_kind(input logic [2:0] m);
      if (m == GRAN_FIX4 || m == GRAN_DYN14) begin
         high_kind = KIND_4X;
      end else if (m == GRAN_FIX2 || m == GRAN_DYN12) begin
         high_kind = KIND_2X;
      end else begin
         high_kind = KIND_1X;
      end
   endfunction

   function automatic logic is_legal(input logic [2:0] m);
      is_legal = (m == GRAN_FIX1) || (m == GRAN_FIX2) ||
                 (m == GRAN_FIX4) || (m == GRAN_DYN12) ||
                 (m == GRAN_DYN14);
   endfunction

   function automatic logic cnt_ok(input logic [2:0] m,
                                   input logic [1:0] c);
      case (high_kind(m))
         KIND_2X: cnt_ok = (c[0] == 1'b0);
         KIND_4X: cnt_ok = (c == '0);
         default: cnt_ok = 1'b1;
      endcase
   endfunction

   function automatic logic [TW-1:0] iv_cycles(input rrm_kind_t k,
                                               input logic ext);
      logic [TW-1:0] v;
      case (k)
         KIND_2X: v = TW'(REFI2_CYC);
         KIND_4X: v = TW'(REFI4_CYC);
         default: v = TW'(REFI1_CYC);
      endcase
      // Timer runs one cycle past its load value
      iv_cycles = (ext ? (v >> 1) : v) - TW'(1);
   endfunction

   function automatic logic [TW-1:0] rfc_cycles(input rrm_kind_t k);
      case (k)
         KIND_2X: rfc_cycles = TW'(RFC2_CYC - 1);
         KIND_4X: rfc_cycles = TW'(RFC4_CYC - 1);
         default: rfc_cycles = TW'(RFC1_CYC - 1);
      endcase
   endfunction

   function automatic rrm_kind_t next_kind(input logic [2:0] m,
                                           input logic [1:0] c,
                                           input logic hi);
      if (!m[GRAN_DYN_BIT] || c != '0 || hi) begin
         next_kind = high_kind(m);
      end else begin
         next_kind = KIND_1X;
      end
   endfunction

   function automatic logic [2:0] mr4_field(input logic temp_controlled_refresh,
                                            input logic ext);
      mr4_field = '0;
      mr4_field[MR4_TCR_BIT] = temp_controlled_refresh;
      mr4_field[MR4_EXT_BIT] = ext;
   endfunction

   logic                ref_en_q;
   logic [2:0]          mode_req_q;
   logic                tcr_req_q;
   logic                ext_req_q;
   logic                dyn_hi_q;
   logic                pend_q;
   logic [2:0]          tgt_mode_q;
   logic                tgt_tcr_q;
   logic                tgt_ext_q;
   logic [2:0]          act_mode_q;
   logic                act_tcr_q;
   logic                act_ext_q;
   logic                err_q;
   logic [1:0]          hi_cnt_q;
   logic [REFCNT_W-1:0] refcnt_q;
   rrm_kind_t           kind_q;
   rrm_state_t          state_q;
   rrm_state_t          state_d;
   rrm_cmd_t            cmd_q;
   logic [DATA_W-1:0]   prdata_q;
   logic [DATA_W-1:0]   rd_d;
   logic                mapped;
   logic                wr_en;
   logic                go;
   logic                go_ok;
   logic                rate_chg;
   logic                due;
   logic                iv_done;
   logic                bz_done;
   logic                iss_ref;
   logic                iss_mr;
   logic                mr_four;
   logic                iv_load;
   logic [TW-1:0]       iv_val;
   logic                bz_load;
   logic [TW-1:0]       bz_val;
   rrm_kind_t           nk;
   logic [TW-1:0]       gap_q;
   logic [TW-1:0]       last_iv_q;

   // APB slave, answers in the first access cycle
   assign wr_en     = psel_i && penable_i && pwrite_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;
   assign prdata_o  = prdata_q;

   always_comb begin
      rd_d   = '0;
      mapped = 1'b1;
      if (paddr_i == ADDR_CTRL) begin
         rd_d[CTRL_EN_BIT]              = ref_en_q;
         rd_d[CTRL_MODE_LSB +: 3]       = mode_req_q;
         rd_d[CTRL_TCR_BIT]             = tcr_req_q;
         rd_d[CTRL_EXT_BIT]             = ext_req_q;
         rd_d[CTRL_DYNHI_BIT]           = dyn_hi_q;
      end else if (paddr_i == ADDR_APPLY) begin
         rd_d[APPLY_GO_BIT]             = pend_q;
      end else if (paddr_i == ADDR_STATUS) begin
         rd_d[STAT_MODE_LSB +: 3]       = act_mode_q;
         rd_d[STAT_TCR_BIT]             = act_tcr_q;
         rd_d[STAT_EXT_BIT]             = act_ext_q;
         rd_d[STAT_PEND_BIT]            = pend_q;
         rd_d[STAT_BUSY_BIT]            = (state_q != ST_IDLE);
         rd_d[STAT_CNT_LSB +: 2]        = hi_cnt_q;
         rd_d[STAT_ERR_BIT]             = err_q;
      end else if (paddr_i == ADDR_REFCNT) begin
         rd_d[REFCNT_W-1:0]             = refcnt_q;
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_q <= '0;
      end else if (psel_i && !penable_i) begin
         prdata_q <= rd_d;
      end
   end

   // Control register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ref_en_q   <= 1'b0;
         mode_req_q <= GRAN_FIX1;
         tcr_req_q  <= 1'b0;
         ext_req_q  <= 1'b0;
         dyn_hi_q   <= 1'b0;
      end else if (wr_en && paddr_i == ADDR_CTRL) begin
         ref_en_q   <= pwdata_i[CTRL_EN_BIT];
         mode_req_q <= pwdata_i[CTRL_MODE_LSB +: 3];
         tcr_req_q  <= pwdata_i[CTRL_TCR_BIT];
         ext_req_q  <= pwdata_i[CTRL_EXT_BIT];
         dyn_hi_q   <= pwdata_i[CTRL_DYNHI_BIT];
      end
   end

   // Mode change request, refused if reserved, pending, or temperature refresh with a mode other than GRAN_FIX1
   assign go    = wr_en && paddr_i == ADDR_APPLY && pwdata_i[APPLY_GO_BIT];
   assign go_ok = !pend_q && is_legal(mode_req_q) &&
                  !(tcr_req_q && mode_req_q != GRAN_FIX1);

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend_q     <= 1'b0;
         tgt_mode_q <= GRAN_FIX1;
         tgt_tcr_q  <= 1'b0;
         tgt_ext_q  <= 1'b0;
      end else if (go && go_ok) begin
         pend_q     <= 1'b1;
         tgt_mode_q <= mode_req_q;
         tgt_tcr_q  <= tcr_req_q;
         tgt_ext_q  <= ext_req_q;
      end else if (state_q == ST_MRW2 && bz_done) begin
         pend_q     <= 1'b0;
      end
   end

   // Error flag, a new refusal wins over the clear
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         err_q <= 1'b0;
      end else if (go && !go_ok) begin
         err_q <= 1'b1;
      end else if (wr_en && paddr_i == ADDR_STATUS &&
                   pwdata_i[STAT_ERR_BIT]) begin
         err_q <= 1'b0;
      end
   end

   // Scheduler
   assign rate_chg = high_kind(tgt_mode_q) != high_kind(act_mode_q);
   assign due      = iv_done && ref_en_q;
   assign nk       = next_kind(act_mode_q, hi_cnt_q, dyn_hi_q);

   always_comb begin
      state_d = state_q;
      iss_ref = 1'b0;
      iss_mr  = 1'b0;
      mr_four = 1'b0;
      iv_load = 1'b0;
      iv_val  = iv_cycles(nk, act_tcr_q && act_ext_q);
      bz_load = 1'b0;
      bz_val  = rfc_cycles(nk);
      case (state_q)
         ST_IDLE: begin
            if (pend_q && (!rate_chg ||
                cnt_ok(act_mode_q, hi_cnt_q))) begin
               iss_mr  = 1'b1;
               mr_four = !tgt_tcr_q;
               bz_load = 1'b1;
               bz_val  = TW'(MRW_GAP_CYC - 1);
               state_d = ST_MRW1;
            end else if (due) begin
               iss_ref = 1'b1;
               iv_load = 1'b1;
               bz_load = 1'b1;
               state_d = ST_REF_WAIT;
            end
         end
         ST_REF_WAIT: begin
            if (bz_done) begin
               state_d = ST_IDLE;
            end
         end
         ST_MRW1: begin
            if (bz_done) begin
               iss_mr  = 1'b1;
               mr_four = tgt_tcr_q;
               bz_load = 1'b1;
               bz_val  = TW'(MRW_GAP_CYC - 1);
               state_d = ST_MRW2;
            end
         end
         ST_MRW2: begin
            if (bz_done) begin
               iv_load = 1'b1;
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   rrm_timer #(.W(TW)) u_iv_timer (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .load_i   (iv_load),
      .value_i  (iv_val),
      .done_o   (iv_done)
   );

   rrm_timer #(.W(TW)) u_busy_timer (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .load_i   (bz_load),
      .value_i  (bz_val),
      .done_o   (bz_done)
   );

   // Active mode as written to the device
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         act_mode_q <= GRAN_FIX1;
         act_tcr_q  <= 1'b0;
         act_ext_q  <= 1'b0;
      end else if (iss_mr && !mr_four) begin
         act_mode_q <= tgt_mode_q;
      end else if (iss_mr && mr_four) begin
         act_tcr_q  <= tgt_tcr_q;
         act_ext_q  <= tgt_ext_q;
      end
   end

   // Fast refresh count since the last single or rate change
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hi_cnt_q <= '0;
      end else if (iss_mr && !mr_four && rate_chg) begin
         hi_cnt_q <= '0;
      end else if (iss_ref) begin
         if (nk == KIND_1X) begin
            hi_cnt_q <= '0;
         end else if (nk == KIND_2X) begin
            hi_cnt_q <= {1'b0, ~hi_cnt_q[0]};
         end else begin
            hi_cnt_q <= hi_cnt_q + 2'h1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         kind_q   <= KIND_1X;
         refcnt_q <= '0;
      end else if (iss_ref) begin
         kind_q   <= nk;
         refcnt_q <= refcnt_q + REFCNT_W'(1);
      end
   end

   // Command outputs
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cmd_q <= '0;
      end else begin
         cmd_q.refresh          <= iss_ref;
         cmd_q.group_select_low <= iss_ref && act_mode_q[GRAN_DYN_BIT] &&
                                   nk != KIND_1X;
         cmd_q.mrw              <= iss_mr;
         cmd_q.mrw_four         <= iss_mr && mr_four;
         cmd_q.field            <= !iss_mr ? 3'h0 :
                                   mr_four ? mr4_field(tgt_tcr_q, tgt_ext_q)
                                           : tgt_mode_q;
      end
   end

   assign cmd_o = cmd_q;

   // Helper for interval checks
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gap_q     <= '0;
         last_iv_q <= '0;
      end else if (iv_load) begin
         gap_q     <= '0;
         last_iv_q <= iv_val;
      end else if (gap_q != '1) begin
         gap_q     <= gap_q + TW'(1);
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   sequence s_quiet;
      !cmd_o.refresh && !cmd_o.mrw;
   endsequence
   sequence s_ref1;
      cmd_o.refresh && kind_q == KIND_1X;
   endsequence
   sequence s_ref2;
      cmd_o.refresh && kind_q == KIND_2X;
   endsequence
   sequence s_ref4;
      cmd_o.refresh && kind_q == KIND_4X;
   endsequence
   sequence s_mr3;
      cmd_o.mrw && !cmd_o.mrw_four;
   endsequence

   AST_RFC1_QUIET: assert property (s_ref1 |=> s_quiet [*3])
      else $error("command inside single rate refresh cycle");
   AST_RFC2_QUIET: assert property (s_ref2 |=> s_quiet [*2])
      else $error("command inside double rate refresh cycle");
   AST_RFC4_QUIET: assert property (s_ref4 |=> s_quiet)
      else $error("command inside quad rate refresh cycle");
   AST_FIXED_KIND: assert property (cmd_o.refresh &&
      !act_mode_q[GRAN_DYN_BIT] |-> kind_q == high_kind(act_mode_q))
      else $error("fixed mode refresh of wrong kind");
   AST_DYN_KIND: assert property (cmd_o.refresh &&
      act_mode_q[GRAN_DYN_BIT] |->
      kind_q == KIND_1X || kind_q == high_kind(act_mode_q))
      else $error("dynamic mode refresh of wrong kind");
   AST_GROUP_SEL: assert property (cmd_o.refresh &&
      act_mode_q[GRAN_DYN_BIT] |->
      cmd_o.group_select_low == (kind_q != KIND_1X))
      else $error("group select does not match refresh kind");
   AST_DYN_PROGRAMMED: assert property (cmd_o.refresh &&
      cmd_o.group_select_low |-> is_legal(act_mode_q) &&
      act_mode_q[GRAN_DYN_BIT])
      else $error("dynamic refresh before dynamic mode written");
   AST_EVEN_DOUBLE: assert property (s_ref1 and
      (act_mode_q == GRAN_DYN12) |-> $past(hi_cnt_q) == 2'h0)
      else $error("odd double rate count between singles");
   AST_QUAD_GROUP: assert property (s_ref1 and
      (act_mode_q == GRAN_DYN14) |-> $past(hi_cnt_q) == 2'h0)
      else $error("quad count not multiple of four");
   AST_RATE_CHANGE: assert property (s_mr3 and
      (high_kind(act_mode_q) != high_kind($past(act_mode_q))) |->
      cnt_ok($past(act_mode_q), $past(hi_cnt_q)))
      else $error("rate changed with incomplete fast group");
   AST_SAME_RATE: assert property (s_mr3 and
      (high_kind(act_mode_q) == high_kind($past(act_mode_q))) |->
      hi_cnt_q == $past(hi_cnt_q))
      else $error("same rate switch disturbed count");
   AST_TCR_FIX1: assert property (s_mr3 and
      (cmd_o.field != GRAN_FIX1) |-> !act_tcr_q)
      else $error("granularity set while temperature refresh on");
   AST_INTERVAL: assert property (cmd_o.refresh |->
      $past(gap_q) >= $past(last_iv_q))
      else $error("refresh issued before interval elapsed");
endmodule

// [src/rrm_pkg.sv]
// Purpose: Constants and types of the refresh rate mode host
// Assumes: 10 MHz clock; APB register access; 32-bit data
// Notes:   Times kept in ns; cycle counts derived from the period
package rrm_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int REFI_BASE_NS  = 7800;
   localparam int RFC1_NS       = 350;
   localparam int RFC2_NS       = 260;
   localparam int RFC4_NS       = 160;
   localparam int MRW_GAP_NS    = 400;

   // Longest times round down, least times round up
   localparam int REFI1_CYC   = REFI_BASE_NS / CLK_PERIOD_NS;
   localparam int REFI2_CYC   = REFI_BASE_NS / (2 * CLK_PERIOD_NS);
   localparam int REFI4_CYC   = REFI_BASE_NS / (4 * CLK_PERIOD_NS);
   localparam int RFC1_CYC    = (RFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RFC2_CYC    = (RFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RFC4_CYC    = (RFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MRW_GAP_CYC = (MRW_GAP_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;

   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int REFCNT_W = 16;

   localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_APPLY  = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_REFCNT = 8'h0c;

   // Control word fields
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_MODE_LSB  = 1;
   localparam int CTRL_TCR_BIT   = 4;
   localparam int CTRL_EXT_BIT   = 5;
   localparam int CTRL_DYNHI_BIT = 6;
   localparam int APPLY_GO_BIT   = 0;

   // Status word fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_TCR_BIT  = 3;
   localparam int STAT_EXT_BIT  = 4;
   localparam int STAT_PEND_BIT = 5;
   localparam int STAT_BUSY_BIT = 6;
   localparam int STAT_CNT_LSB  = 7;
   localparam int STAT_ERR_BIT  = 9;

   // Granularity field of mode_register_three
   localparam logic [2:0] GRAN_FIX1  = 3'h0;
   localparam logic [2:0] GRAN_FIX2  = 3'h1;
   localparam logic [2:0] GRAN_FIX4  = 3'h2;
   localparam logic [2:0] GRAN_DYN12 = 3'h5;
   localparam logic [2:0] GRAN_DYN14 = 3'h6;
   localparam int         GRAN_DYN_BIT = 2;

   // temp_controlled_refresh bits of mode_register_four
   localparam int MR4_TCR_BIT = 1;
   localparam int MR4_EXT_BIT = 0;

   typedef enum logic [1:0] {KIND_1X, KIND_2X, KIND_4X} rrm_kind_t;

   typedef enum {ST_IDLE, ST_REF_WAIT, ST_MRW1, ST_MRW2} rrm_state_t;

   typedef struct packed {
      logic       refresh;
      logic       group_select_low;
      logic       mrw;
      logic       mrw_four;
      logic [2:0] field;
   } rrm_cmd_t;
endpackage

// [src/rrm_timer.sv]
// Purpose: Loadable down counter used for intervals and waits
// Assumes: Load value counts cycles until done
// Notes:   Holds at zero until loaded again
`timescale 1ns/1ps
module rrm_timer #(
   parameter int W = 8
) (
   input  wire logic         clock_i,
   input  wire logic         resetn_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] value_i,
   output logic              done_o
);
   logic [W-1:0] count_q;

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_q <= '0;
      end else if (load_i) begin
         count_q <= value_i;
      end else if (count_q != '0) begin
         count_q <= count_q - W'(1);
      end
   end

   assign done_o = (count_q == '0);
endmodule

// [sim/rrm_dev_model.sv]
// Purpose: Device side model of the refresh rate modes
// Assumes: Commands sampled at each rising edge
// Notes:   Protocol faults counted in errors_o
`timescale 1ns/1ps
module rrm_dev_model (
   input  wire logic              clock_i,
   input  wire logic              resetn_i,
   input  wire rrm_pkg::rrm_cmd_t cmd_i,
   output logic [2:0]             mode_o,
   output logic                   tcr_o,
   output logic [15:0]            errors_o
);
   import rrm_pkg::*;
   int         gap_q;
   int         fast_q;
   logic       fast;
   logic       bad;
   logic [2:0] f;
   assign f = cmd_i.field;
   // Fast kind from mode and group bit
   assign fast = mode_o[2] ? cmd_i.group_select_low : (mode_o != 3'h0);
   always_comb begin
      bad = cmd_i.refresh && mode_o[2] && !fast && fast_q != 0;
      if (cmd_i.refresh && !mode_o[2] && cmd_i.group_select_low) bad = 1;
      if ((cmd_i.refresh || cmd_i.mrw) && gap_q > 1) bad = 1'b1;
      if (cmd_i.mrw && !cmd_i.mrw_four) begin
         if (f == 3'h3 || f == 3'h4 || f == 3'h7) bad = 1'b1;
         if (f != 3'h0 && tcr_o) bad = 1'b1;
         if (f[1:0] != mode_o[1:0] && fast_q != 0) bad = 1'b1;
      end
      if (cmd_i.mrw && cmd_i.mrw_four && f[1] && mode_o != 3'h0) bad = 1;
   end
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_o   <= GRAN_FIX1;
         tcr_o    <= 1'b0;
         errors_o <= 16'h0;
         gap_q    <= 0;
         fast_q   <= 0;
      end else begin
         gap_q <= (gap_q > 0) ? gap_q - 1 : 0;
         if (bad) errors_o <= errors_o + 16'h1;
         if (cmd_i.refresh) begin
            // Cycle time of this refresh kind
            gap_q  <= !fast ? RFC1_CYC : mode_o[1] ? RFC4_CYC : RFC2_CYC;
            fast_q <= !fast ? 0 : (fast_q + 1) % (mode_o[1] ? 4 : 2);
         end
         if (cmd_i.mrw && !cmd_i.mrw_four && !bad) begin
            mode_o <= f;
            if (f[1:0] != mode_o[1:0]) fast_q <= 0;
         end
         if (cmd_i.mrw && cmd_i.mrw_four) tcr_o <= f[1];
      end
   end
endmodule

// [sim/testbench.sv]
// Purpose: Self-checking bench of the refresh rate host
// Assumes: APB master waits for pready; device model on cmd_o
// Notes:   Refresh spacing measured on cmd_o
`timescale 1ns/1ps
module testbench;
   import rrm_pkg::*;
   logic        clock_i;
   logic        resetn_i;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   rrm_cmd_t    cmd;
   logic [2:0]  dev_mode;
   logic        dev_tcr;
   logic [15:0] dev_err;
   logic [31:0] rd_q;
   logic        err_q;
   logic [31:0] rng;
   logic        last_grp;
   int          failures = 0;
   int          checked = 0;
   int          cyc = 0;
   int          last_ref = 0;
   int          last_gap = 0;
   int          ref_n = 0;
   logic [2:0]  modes [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h0};

   rrm_refresh_host #(.TW(8)) u_rrm_refresh_host (
      .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .cmd_o(cmd));
   rrm_dev_model u_rrm_dev_model (
      .clock_i(clock_i), .resetn_i(resetn_i), .cmd_i(cmd),
      .mode_o(dev_mode), .tcr_o(dev_tcr), .errors_o(dev_err));

   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cmd.refresh === 1'b1) begin
         last_gap <= cyc - last_ref;
         last_ref <= cyc;
         last_grp <= cmd.group_select_low;
         ref_n    <= ref_n + 1;
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd_q  = prdata;
      err_q = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic apply(input logic [2:0] m, input logic t, e, dy);
      int n;
      n = 0;
      apb(1'b1, ADDR_CTRL, {25'h0, dy, e, t, m, 1'b1});
      apb(1'b1, ADDR_APPLY, 32'h1);
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         n++;
      end while (rd_q[STAT_PEND_BIT] !== 1'b0 && n < 200);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock_i);
      failures++;
      give_verdict();
   end

   initial begin
      logic [2:0] m;
      int         dv;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 8'h0;
      pwdata   = 32'h0;
      rng      = 32'hd;
      resetn_i = 1'b0;
      repeat (8) @(posedge clock_i);
      resetn_i <= 1'b1;
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status", rd_q, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check("slverr", 32'(err_q), 32'h1);
      check("unmapped", rd_q, 32'h0);
      $display("test reset done");
      foreach (modes[i]) begin
         rng = xs(rng);
         m = modes[i];
         apply(m, 1'b0, 1'b0, rng[0]);
         check("mode", rd_q & 32'h20f, 32'(m));
         check("dev_mode", 32'(dev_mode), 32'(m));
         repeat (250) @(posedge clock_i);
         dv = (m[2] ? rng[0] : (m != 3'h0)) ? (m[1] ? 4 : 2) : 1;
         check("gap", 32'(last_gap), REFI_BASE_NS / (dv * CLK_PERIOD_NS));
         check("group", 32'(last_grp), 32'(m[2] & rng[0]));
         $display("test mode %h done", m);
      end
      apply(3'h3, 1'b0, 1'b0, 1'b0);
      check("reserved", rd_q & 32'h20f, 32'h200);
      apb(1'b1, ADDR_STATUS, 32'h200);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("clear", rd_q & 32'h20f, 32'h0);
      apply(3'h1, 1'b1, 1'b0, 1'b0);
      check("tcr_bad", rd_q & 32'h20f, 32'h200);
      apb(1'b1, ADDR_STATUS, 32'h200);
      apply(3'h0, 1'b1, 1'b1, 1'b0);
      check("tcr", rd_q & 32'h21f, 32'h18);
      check("dev_tcr", 32'(dev_tcr), 32'h1);
      repeat (250) @(posedge clock_i);
      check("ext_gap", 32'(last_gap), REFI_BASE_NS / (2 * CLK_PERIOD_NS));
      $display("test refusals done");
      apb(1'b1, ADDR_CTRL, 32'h0);
      repeat (200) @(posedge clock_i);
      apb(1'b0, ADDR_REFCNT, 32'h0);
      check("refcnt", rd_q, 32'(ref_n[15:0]));
      check("dev_err", 32'(dev_err), 32'h0);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      resetn_i <= 1'b1;
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("rst_status", rd_q, 32'h0);
      $display("test stop and reset done");
      give_verdict();
   end
endmodule
